// [common/uart_pkg.sv]
// Purpose: Constants, types and helpers shared by the serial port design
// Assumes: clk is the divider reference; word-indexed register port
// Notes: Register fields sit in the low bits, unused bits read zero
package uart_pkg;
  // ============================================================
  // Register map (word index)
  localparam logic [2:0] ADDR_DATA = 3'h0;
  localparam logic [2:0] ADDR_DIV = 3'h1;
  localparam logic [2:0] ADDR_LCTL = 3'h2;
  localparam logic [2:0] ADDR_STATUS = 3'h3;
  localparam logic [2:0] ADDR_INTSTAT = 3'h4;
  localparam logic [2:0] ADDR_INTMASK = 3'h5;
  localparam logic [2:0] ADDR_DIAG = 3'h6;
  // ============================================================
  // Line control fields
  localparam int LC_LEN = 0;
  localparam int LC_STOP2 = 2;
  localparam int LC_PAREN = 3;
  localparam int LC_EVEN = 4;
  localparam int LC_BREAK = 5;
  localparam int LC_LOOP = 6;
  localparam int LC_ARTS = 7;
  localparam int LC_ACTS = 8;
  localparam int LC_TRIG = 9;
  localparam int LC_RTSON = 11;
  localparam logic [11:0] LC_FLOWBITS = 12'h980;
  // ============================================================
  // Event bits: status, mask and injection share this layout
  localparam int EV_RXTRIG = 0;
  localparam int EV_TXEMPTY = 1;
  localparam int EV_OVERRUN = 2;
  localparam int EV_PARITY = 3;
  localparam int EV_FRAMING = 4;
  localparam int EV_BREAK = 5;
  // ============================================================
  // Reset values and timing counts
  localparam logic [15:0] DIV_RST = 16'h0001;
  localparam logic [11:0] LCTL_RST = 12'h003;
  localparam logic [5:0] MASK_RST = 6'h00;
  localparam logic [5:0] BIT_LAST = 6'h0f;
  localparam logic [5:0] START_MID = 6'h07;
  localparam logic [5:0] STOP1_TICKS = 6'h10;
  localparam logic [5:0] STOP15_TICKS = 6'h18;
  localparam logic [5:0] STOP2_TICKS = 6'h20;
  localparam logic [4:0] FIFO_DEPTH = 5'h10;

  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_WAIT} rxState_t;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} txState_t;

  function automatic logic [3:0] dataBits(input logic [1:0] len);
    return 4'h5 + {2'h0, len};
  endfunction

  function automatic logic [4:0] trigLevel(input logic [1:0] sel);
    logic [4:0] lvl;
    unique case (sel)
      2'h0: lvl = 5'h01;
      2'h1: lvl = 5'h04;
      2'h2: lvl = 5'h08;
      2'h3: lvl = 5'h0e;
    endcase
    return lvl;
  endfunction

  function automatic logic parityBit(input logic [7:0] d, input logic [1:0] len, input logic even);
    logic [7:0] m;
    m = 8'hff >> (2'h3 - len);
    return even ? ^(d & m) : ~^(d & m);
  endfunction
endpackage

// [common/uart_fifo_if.sv]
// Purpose: Push/pop port of a byte queue
// Assumes: Owner and user share one clock
// Notes: popData shows the head while not empty
`timescale 1ns/100ps
interface uart_fifo_if;
  logic push;
  logic [7:0] pushData;
  logic pop;
  logic [7:0] popData;
  logic [4:0] count;
  logic full;
  logic empty;
  modport store (input push, input pushData, input pop,
                 output popData, output count, output full, output empty);
  modport user (output push, output pushData, output pop,
                input popData, input count, input full, input empty);
endinterface

// [src/uart_fifo.sv]
// Purpose: Sixteen-byte first-in first-out queue
// Assumes: Push when full and pop when empty are ignored
// Notes: Head word read without latency
`timescale 1ns/100ps
module uart_fifo (
  input wire logic clk,
  input wire logic sys_rst,
  uart_fifo_if.store q
);
  logic [7:0] mem_r [16];
  logic [3:0] wrPtr_r;
  logic [3:0] rdPtr_r;
  logic [4:0] count_r;
  logic doPush;
  logic doPop;

  assign doPush = q.push && (count_r != uart_pkg::FIFO_DEPTH);
  assign doPop = q.pop && (count_r != 5'h00);

  always_ff @(posedge clk) begin
    if (doPush) begin
      mem_r[wrPtr_r] <= q.pushData;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wrPtr_r <= 4'h0;
      rdPtr_r <= 4'h0;
      count_r <= 5'h00;
    end else begin
      if (doPush) wrPtr_r <= wrPtr_r + 4'h1;
      if (doPop) rdPtr_r <= rdPtr_r + 4'h1;
      count_r <= count_r + {4'h0, doPush} - {4'h0, doPop};
    end
  end

  assign q.popData = mem_r[rdPtr_r];
  assign q.count = count_r;
  assign q.full = count_r == uart_pkg::FIFO_DEPTH;
  assign q.empty = count_r == 5'h00;

  fifo_bound_a: assert property (@(posedge clk) disable iff (sys_rst)
    count_r <= uart_pkg::FIFO_DEPTH) else $error("queue count past depth");
  fifo_full_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    q.full && q.push && !q.pop |=> count_r == uart_pkg::FIFO_DEPTH)
    else $error("push into full queue changed count");
endmodule

// [src/uart_baud.sv]
// Purpose: Sixteen-times bit clock enable from a divisor
// Assumes: Divisor zero behaves as one
// Notes: New divisor applies at once, to the period in progress
`timescale 1ns/100ps
module uart_baud (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [15:0] divisor,
  output logic tick
);
  logic [15:0] cnt_r;
  logic [15:0] last;

  assign last = (divisor == 16'h0000) ? 16'h0000 : divisor - 16'h0001;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_r <= 16'h0000;
      tick <= 1'b0;
    end else if (cnt_r >= last) begin
      cnt_r <= 16'h0000;
      tick <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 16'h0001;
      tick <= 1'b0;
    end
  end

  baud_spacing_a: assert property (@(posedge clk) disable iff (sys_rst)
    tick && divisor == 16'h0003 ##1 divisor == 16'h0003 ##1 divisor == 16'h0003
    |=> tick && !$past(tick) && !$past(tick, 2))
    else $error("tick spacing does not follow divisor");
endmodule

// [src/uart_with_fifos_and_autoflow.sv]
// Purpose: Serial transceiver with queues, flow control and DMA requests
// Assumes: clk is the divider reference; rxd and ctsN synchronous to clk
// Notes: HAS_FLOW selects the instance with RTS/CTS
//
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
module uart_with_fifos_and_autoflow #(
  parameter bit HAS_FLOW = 1'b1
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [2:0] addr,
  input wire logic [31:0] wrData,
  input wire logic wrStb,
  input wire logic rdStb,
  output logic [31:0] rdData,
  input wire logic rxd,
  input wire logic ctsN,
  output logic txd,
  output logic rtsN,
  output logic irq,
  output logic rxDmaReq,
  output logic txDmaReq
);
  // ============================================================
  // Configuration
  logic [15:0] div_r;
  logic [11:0] lctl_r;
  logic [5:0] intMask_r;
  logic [5:0] intStat_r;
  logic [1:0] lenSel;
  logic [3:0] nBits;
  logic parEn;
  logic parEven;
  logic brk;
  logic loop;
  logic autoRts;
  logic autoCts;
  logic rtsOn;
  logic [4:0] trig;
  logic [5:0] stopTicks;
  logic ctsOk;
  logic tick;

  assign lenSel = lctl_r[uart_pkg::LC_LEN +: 2];
  assign nBits = uart_pkg::dataBits(lenSel);
  assign parEn = lctl_r[uart_pkg::LC_PAREN];
  assign parEven = lctl_r[uart_pkg::LC_EVEN];
  assign brk = lctl_r[uart_pkg::LC_BREAK];
  assign loop = lctl_r[uart_pkg::LC_LOOP];
  assign autoRts = lctl_r[uart_pkg::LC_ARTS];
  assign autoCts = lctl_r[uart_pkg::LC_ACTS];
  assign rtsOn = lctl_r[uart_pkg::LC_RTSON];
  assign trig = uart_pkg::trigLevel(lctl_r[uart_pkg::LC_TRIG +: 2]);
  // Half stop only exists for five-bit characters
  assign stopTicks = !lctl_r[uart_pkg::LC_STOP2] ? uart_pkg::STOP1_TICKS :
                     (lenSel == 2'h0) ? uart_pkg::STOP15_TICKS : uart_pkg::STOP2_TICKS;
  assign ctsOk = !(HAS_FLOW && autoCts && ctsN);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      div_r <= uart_pkg::DIV_RST;
      lctl_r <= uart_pkg::LCTL_RST;
      intMask_r <= uart_pkg::MASK_RST;
    end else if (wrStb) begin
      unique case (addr)
        uart_pkg::ADDR_DIV: div_r <= wrData[15:0];
        // Modem bits stay zero on instances without the pins
        uart_pkg::ADDR_LCTL: lctl_r <= HAS_FLOW ? wrData[11:0] :
                                       (wrData[11:0] & ~uart_pkg::LC_FLOWBITS);
        uart_pkg::ADDR_INTMASK: intMask_r <= wrData[5:0];
        default: ;
      endcase
    end
  end

  // Clock as reference caps the bit rate at 1.25 MHz, inside both limits
  uart_baud baudGen (
    .clk(clk),
    .sys_rst(sys_rst),
    .divisor(div_r),
    .tick(tick)
  );

  // ============================================================
  // Queues
  uart_fifo_if txQ ();
  uart_fifo_if rxQ ();

  uart_fifo txFifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .q(txQ)
  );

  uart_fifo rxFifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .q(rxQ)
  );

  // ============================================================
  // Transmitter
  uart_pkg::txState_t txState_r;
  logic [5:0] txCnt_r;
  logic [2:0] txBit_r;
  logic [7:0] txShift_r;
  logic txPar_r;
  logic txLine_r;
  logic txPop;
  logic txBitEnd;

  assign txPop = (txState_r == uart_pkg::TX_IDLE) && !txQ.empty && ctsOk;
  assign txQ.pop = txPop;
  assign txQ.push = wrStb && (addr == uart_pkg::ADDR_DATA);
  assign txQ.pushData = wrData[7:0];
  assign txBitEnd = tick && (txCnt_r == ((txState_r == uart_pkg::TX_STOP) ?
                             stopTicks - 6'h01 : uart_pkg::BIT_LAST));

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      txState_r <= uart_pkg::TX_IDLE;
      txCnt_r <= 6'h00;
      txBit_r <= 3'h0;
      txShift_r <= 8'h00;
      txPar_r <= 1'b0;
      txLine_r <= 1'b1;
    end else if (txState_r == uart_pkg::TX_IDLE) begin
      txLine_r <= 1'b1;
      if (txPop) begin
        txShift_r <= txQ.popData;
        txPar_r <= uart_pkg::parityBit(txQ.popData, lenSel, parEven);
        txLine_r <= 1'b0;
        txCnt_r <= 6'h00;
        txState_r <= uart_pkg::TX_START;
      end
    end else if (tick && !txBitEnd) begin
      txCnt_r <= txCnt_r + 6'h01;
    end else if (txBitEnd) begin
      txCnt_r <= 6'h00;
      unique case (txState_r)
        uart_pkg::TX_START: begin
          txLine_r <= txShift_r[0];
          txBit_r <= 3'h0;
          txState_r <= uart_pkg::TX_DATA;
        end
        uart_pkg::TX_DATA: begin
          if ({1'b0, txBit_r} == nBits - 4'h1) begin
            txLine_r <= parEn ? txPar_r : 1'b1;
            txState_r <= parEn ? uart_pkg::TX_PAR : uart_pkg::TX_STOP;
          end else begin
            txLine_r <= txShift_r[1];
            txShift_r <= {1'b0, txShift_r[7:1]};
            txBit_r <= txBit_r + 3'h1;
          end
        end
        uart_pkg::TX_PAR: begin
          txLine_r <= 1'b1;
          txState_r <= uart_pkg::TX_STOP;
        end
        default: txState_r <= uart_pkg::TX_IDLE;
      endcase
    end
  end

  // Loopback keeps the pin idle so the far end sees no traffic; break still drives it low
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      txd <= 1'b1;
    end else begin
      txd <= brk ? 1'b0 : (loop ? 1'b1 : txLine_r);
    end
  end

  // ============================================================
  // Receiver
  uart_pkg::rxState_t rxState_r;
  logic [5:0] rxCnt_r;
  logic [2:0] rxBit_r;
  logic [7:0] rxShift_r;
  logic rxParBad_r;
  logic rxPush_r;
  logic evOvr_r;
  logic evPar_r;
  logic evFrm_r;
  logic evBrk_r;
  logic rxLine;
  logic rxSample;

  assign rxLine = loop ? txLine_r : rxd;
  assign rxSample = tick && (rxCnt_r == uart_pkg::BIT_LAST);
  assign rxQ.push = rxPush_r;
  assign rxQ.pushData = rxShift_r;
  assign rxQ.pop = rdStb && (addr == uart_pkg::ADDR_DATA) && !rxQ.empty;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rxState_r <= uart_pkg::RX_IDLE;
      rxCnt_r <= 6'h00;
      rxBit_r <= 3'h0;
      rxShift_r <= 8'h00;
      rxParBad_r <= 1'b0;
      rxPush_r <= 1'b0;
      evOvr_r <= 1'b0;
      evPar_r <= 1'b0;
      evFrm_r <= 1'b0;
      evBrk_r <= 1'b0;
    end else begin
      rxPush_r <= 1'b0;
      evOvr_r <= 1'b0;
      evPar_r <= 1'b0;
      evFrm_r <= 1'b0;
      evBrk_r <= 1'b0;
      if (tick && !rxSample) rxCnt_r <= rxCnt_r + 6'h01;
      unique case (rxState_r)
        uart_pkg::RX_IDLE: begin
          rxCnt_r <= 6'h00;
          if (!rxLine) rxState_r <= uart_pkg::RX_START;
        end
        uart_pkg::RX_START: begin
          if (tick && rxCnt_r == uart_pkg::START_MID) begin
            rxCnt_r <= 6'h00;
            rxBit_r <= 3'h0;
            rxShift_r <= 8'h00;
            rxParBad_r <= 1'b0;
            // A glitch that is gone by mid-bit is not a start
            rxState_r <= rxLine ? uart_pkg::RX_IDLE : uart_pkg::RX_DATA;
          end
        end
        uart_pkg::RX_DATA: begin
          if (rxSample) begin
            rxCnt_r <= 6'h00;
            rxShift_r[rxBit_r] <= rxLine;
            if ({1'b0, rxBit_r} == nBits - 4'h1) begin
              rxState_r <= parEn ? uart_pkg::RX_PAR : uart_pkg::RX_STOP;
            end else begin
              rxBit_r <= rxBit_r + 3'h1;
            end
          end
        end
        uart_pkg::RX_PAR: begin
          if (rxSample) begin
            rxCnt_r <= 6'h00;
            rxParBad_r <= rxLine != uart_pkg::parityBit(rxShift_r, lenSel, parEven);
            rxState_r <= uart_pkg::RX_STOP;
          end
        end
        uart_pkg::RX_STOP: begin
          if (rxSample) begin
            rxCnt_r <= 6'h00;
            if (!rxLine && rxShift_r == 8'h00) begin
              evBrk_r <= 1'b1;
            end else begin
              rxPush_r <= !rxQ.full;
              evOvr_r <= rxQ.full;
              evFrm_r <= !rxLine;
              evPar_r <= rxParBad_r;
            end
            // Held-low line must rise before a new start is taken
            rxState_r <= rxLine ? uart_pkg::RX_IDLE : uart_pkg::RX_WAIT;
          end
        end
        uart_pkg::RX_WAIT: begin
          rxCnt_r <= 6'h00;
          if (rxLine) rxState_r <= uart_pkg::RX_IDLE;
        end
        default: rxState_r <= uart_pkg::RX_IDLE;
      endcase
    end
  end

  // ============================================================
  // Interrupt status, flow control and DMA
  logic [5:0] evSet;
  logic [5:0] inj;
  logic [5:0] clr;

  assign inj = (wrStb && addr == uart_pkg::ADDR_DIAG) ? wrData[5:0] : 6'h00;
  assign clr = (wrStb && addr == uart_pkg::ADDR_INTSTAT) ? wrData[5:0] : 6'h00;
  always_comb begin
    evSet = inj & 6'h3c;
    evSet[uart_pkg::EV_RXTRIG] = rxQ.count >= trig;
    evSet[uart_pkg::EV_TXEMPTY] = txPop && txQ.count == 5'h01;
    evSet[uart_pkg::EV_OVERRUN] = evSet[uart_pkg::EV_OVERRUN] | evOvr_r;
    evSet[uart_pkg::EV_PARITY] = evSet[uart_pkg::EV_PARITY] | evPar_r;
    evSet[uart_pkg::EV_FRAMING] = evSet[uart_pkg::EV_FRAMING] | evFrm_r;
    evSet[uart_pkg::EV_BREAK] = evSet[uart_pkg::EV_BREAK] | evBrk_r;
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      intStat_r <= 6'h00;
      irq <= 1'b0;
    end else begin
      intStat_r <= (intStat_r & ~clr) | evSet;
      irq <= |(intStat_r & intMask_r);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rtsN <= 1'b1;
      rxDmaReq <= 1'b0;
      txDmaReq <= 1'b0;
    end else begin
      rtsN <= !(HAS_FLOW && rtsOn && !(autoRts && rxQ.count >= trig));
      rxDmaReq <= rxQ.count >= trig;
      txDmaReq <= txQ.empty;
    end
  end

  // ============================================================
  // Register reads
  logic [31:0] statusWord;

  assign statusWord = {11'h000, txQ.count, 3'h0, rxQ.count, 3'h0, !ctsN,
                       txState_r == uart_pkg::TX_IDLE, txQ.empty, txQ.full, !rxQ.empty};

  always_ff @(posedge clk) begin
    if (sys_rst || !rdStb) begin
      rdData <= 32'h0000_0000;
    end else begin
      unique case (addr)
        uart_pkg::ADDR_DATA: rdData <= rxQ.empty ? 32'h0 : {24'h0, rxQ.popData};
        uart_pkg::ADDR_DIV: rdData <= {16'h0, div_r};
        uart_pkg::ADDR_LCTL: rdData <= {20'h0, lctl_r};
        uart_pkg::ADDR_STATUS: rdData <= statusWord;
        uart_pkg::ADDR_INTSTAT: rdData <= {26'h0, intStat_r};
        uart_pkg::ADDR_INTMASK: rdData <= {26'h0, intMask_r};
        default: rdData <= 32'h0000_0000;
      endcase
    end
  end

  // ============================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence txLaunch;
    txPop ##1 txState_r == uart_pkg::TX_START;
  endsequence

  tx_start_low_a: assert property (txLaunch |-> !txLine_r)
    else $error("start bit not low");
  tx_cts_gate_a: assert property (HAS_FLOW && autoCts && ctsN |-> !txPop)
    else $error("character launched while CTS deasserted");
  rx_false_start_a: assert property (rxState_r == uart_pkg::RX_START && tick &&
    rxCnt_r == uart_pkg::START_MID && rxLine |=> rxState_r == uart_pkg::RX_IDLE)
    else $error("noise accepted as start");
  rx_framing_a: assert property (rxState_r == uart_pkg::RX_STOP && rxSample &&
    !rxLine && rxShift_r != 8'h00 |=> ##1 intStat_r[uart_pkg::EV_FRAMING])
    else $error("low stop not flagged");
  tx_break_a: assert property (brk |=> !txd)
    else $error("break not driven");
  loop_quiet_a: assert property (loop && !brk |=> txd)
    else $error("pin active in loopback");
  auto_rts_a: assert property (HAS_FLOW && autoRts && rxQ.count >= trig |=> rtsN)
    else $error("RTS still asserted above threshold");
  rx_dma_a: assert property (rxQ.count >= trig |=> rxDmaReq)
    else $error("receive DMA request missing");
  irq_level_a: assert property ((intStat_r & intMask_r) != 6'h00 |=> irq)
    else $error("interrupt missing");
  diag_inject_a: assert property (wrStb && addr == uart_pkg::ADDR_DIAG &&
    wrData[uart_pkg::EV_PARITY] |=> intStat_r[uart_pkg::EV_PARITY])
    else $error("injected parity error not recorded");
  stop_len_a: assert property (txState_r == uart_pkg::TX_STOP |->
    txCnt_r < stopTicks) else $error("stop period overrun");
endmodule

// [verification/serial_peer.sv]
// Purpose: Far-end serial device: drives frames into rxd, samples frames on txd
// Assumes: Bench sets bitCyc to sixteen clocks times the divisor
// Notes: Ignores RTS on purpose so receive overflow can be provoked
`timescale 1ns/100ps
module serial_peer (
  input wire logic clk,
  input wire logic txd,
  output logic rxd
);
  int bitCyc = 16;

  initial rxd = 1'b1;

  // ============================================================
  // Sending
  task automatic hold(input logic v, input int n);
    rxd <= v;
    repeat (n) @(posedge clk);
  endtask

  task automatic sendFrame(input logic [7:0] d, input int nb, input logic pe,
                           input logic par, input logic stopLvl);
    hold(1'b0, bitCyc);
    for (int i = 0; i < nb; i++) hold(d[i], bitCyc);
    if (pe) hold(par, bitCyc);
    hold(stopLvl, bitCyc);
    hold(1'b1, 2 * bitCyc);
  endtask

  // ============================================================
  // Receiving
  // Gap runs from the end of the last data or parity bit, across the stop period, to the next start, capped
  task automatic getFrame(input int nb, input logic pe, output logic [7:0] d,
                          output logic p, output int gap);
    int n;
    n = 0;
    d = 8'h00;
    p = 1'b0;
    gap = 0;
    while (txd !== 1'b0 && n < 20000) begin
      @(posedge clk);
      n++;
    end
    repeat (bitCyc / 2) @(posedge clk);
    for (int i = 0; i < nb; i++) begin
      repeat (bitCyc) @(posedge clk);
      d[i] = txd;
    end
    if (pe) begin
      repeat (bitCyc) @(posedge clk);
      p = txd;
    end
    repeat (bitCyc / 2) @(posedge clk);
    while (txd === 1'b1 && gap < 200) begin
      @(posedge clk);
      gap++;
    end
  endtask
endmodule

// [verification/tb.sv]
// Purpose: Self-checking bench for the serial port with queues and flow control
// Assumes: Divisor 1 unless changed, so one bit lasts 16 clocks
// Notes: Peer model stands on the serial side
`timescale 1ns/100ps
module tb;
  localparam logic [31:0] ALL = 32'hffffffff;
  logic clk, sys_rst, wrStb, rdStb, rxd, ctsN, txd, rtsN, irq, rxDmaReq, txDmaReq, p;
  logic rtsN2;
  logic [31:0] rdData2;
  logic [2:0] addr;
  logic [2:0] c;
  logic [31:0] wrData, rdData, v;
  logic [7:0] b, got, mk;
  int fail_count = 0;
  int compares = 0;
  int s, nb, stp;

  uart_with_fifos_and_autoflow DUT (.clk(clk), .sys_rst(sys_rst), .addr(addr),
    .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .rxd(rxd),
    .ctsN(ctsN), .txd(txd), .rtsN(rtsN), .irq(irq), .rxDmaReq(rxDmaReq),
    .txDmaReq(txDmaReq));
  // Instance without modem pins shares the bus and the receive line
  uart_with_fifos_and_autoflow #(.HAS_FLOW(1'b0)) DUT2 (.clk(clk), .sys_rst(sys_rst),
    .addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData2),
    .rxd(rxd), .ctsN(ctsN), .txd(), .rtsN(rtsN2), .irq(), .rxDmaReq(), .txDmaReq());
  serial_peer peer (.clk(clk), .txd(txd), .rxd(rxd));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ============================================================
  // Register access and comparison
  // One idle cycle after each strobe keeps every strobe a clean pulse
  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    addr <= a;
    wrData <= d;
    wrStb <= 1'b1;
    @(posedge clk);
    wrStb <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [2:0] a, output logic [31:0] d);
    addr <= a;
    rdStb <= 1'b1;
    @(posedge clk);
    rdStb <= 1'b0;
    @(posedge clk);
    d = rdData;
  endtask

  task automatic check(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic checkRange(input int g, input int lo, input int hi);
    compares++;
    if (g < lo || g > hi) begin
      fail_count++;
      $display("mismatch at %0t got %h exp %h..%h", $time, g, lo, hi);
    end
  endtask

  task automatic pin(input logic g, input logic e);
    check({31'h0, g}, {31'h0, e});
  endtask

  task automatic rdChk(input logic [2:0] a, input logic [31:0] e, input logic [31:0] m);
    logic [31:0] d;
    rd(a, d);
    check(d & m, e);
  endtask

  task automatic print_verdict;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // ============================================================
  // Tests
  initial begin
    sys_rst = 1'b1;
    addr = 3'h0;
    wrData = 32'h0;
    wrStb = 1'b0;
    rdStb = 1'b0;
    ctsN = 1'b0;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    pin(txDmaReq, 1'b1);
    pin(rtsN, 1'b1);
    pin(txd, 1'b1);
    rdChk(uart_pkg::ADDR_DIV, 32'h1, 32'hffff);
    rdChk(uart_pkg::ADDR_LCTL, 32'h3, 32'hfff);
    rdChk(3'h7, 32'h0, ALL);
    // Transmit held by CTS while the queue fills past its depth
    ctsN <= 1'b1;
    wr(uart_pkg::ADDR_LCTL, 32'h103);
    for (int i = 0; i < 17; i++) wr(uart_pkg::ADDR_DATA, 32'h80 + i);
    rdChk(uart_pkg::ADDR_STATUS, 32'h100002, 32'h1f0002);
    pin(txDmaReq, 1'b0);
    pin(txd, 1'b1);
    ctsN <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      peer.getFrame(8, 1'b0, got, p, s);
      check({24'h0, got}, 32'h80 + i);
    end
    pin(txDmaReq, 1'b1);
    // Every length, parity mode and stop period on the wire
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      nb = 5 + i % 4;
      stp = c[2] ? ((c[1:0] == 2'h0) ? 24 : 32) : 16;
      mk = 8'((1 << nb) - 1);
      b = 8'h5a ^ 8'(i * 37);
      wr(uart_pkg::ADDR_LCTL, {27'h0, c[1], c[0] | c[2], c[2], 2'(c)});
      wr(uart_pkg::ADDR_DATA, {24'h0, b});
      wr(uart_pkg::ADDR_DATA, {24'h0, ~b});
      peer.getFrame(nb, c[0] | c[2], got, p, s);
      check({24'h0, got}, {24'h0, b & mk});
      if (c[0] | c[2]) pin(p, (^(b & mk)) ~^ c[1]);
      checkRange(s, stp - 2, stp + 4);
      peer.getFrame(nb, c[0] | c[2], got, p, s);
      check({24'h0, got}, {24'h0, ~b & mk});
    end
    wr(uart_pkg::ADDR_LCTL, 32'h3);
    wr(uart_pkg::ADDR_DIV, 32'h3);
    peer.bitCyc = 48;
    wr(uart_pkg::ADDR_DATA, 32'hc3);
    peer.getFrame(8, 1'b0, got, p, s);
    check({24'h0, got}, 32'hc3);
    peer.sendFrame(8'h71, 8, 1'b0, 1'b0, 1'b1);
    rdChk(uart_pkg::ADDR_DATA, 32'h71, ALL);
    wr(uart_pkg::ADDR_DIV, 32'h1);
    peer.bitCyc = 16;
    wr(uart_pkg::ADDR_LCTL, 32'h43);
    wr(uart_pkg::ADDR_DATA, 32'h96);
    s = 0;
    repeat (250) begin
      @(posedge clk);
      if (txd !== 1'b1) s++;
    end
    checkRange(s, 0, 0);
    rdChk(uart_pkg::ADDR_DATA, 32'h96, ALL);
    wr(uart_pkg::ADDR_LCTL, 32'h23);
    repeat (3) @(posedge clk);
    pin(txd, 1'b0);
    wr(uart_pkg::ADDR_LCTL, 32'h1a);
    repeat (3) @(posedge clk);
    pin(txd, 1'b1);
    peer.sendFrame(8'h2c, 7, 1'b1, ^8'h2c, 1'b1);
    rdChk(uart_pkg::ADDR_DATA, 32'h2c, ALL);
    peer.hold(1'b0, 4);
    peer.hold(1'b1, 200);
    rdChk(uart_pkg::ADDR_STATUS, 32'h0, 32'h1);
    // Bad parity, low stop, then an all-zero frame with low stop
    for (int j = 0; j < 3; j++) begin
      b = (j == 2) ? 8'h00 : 8'h2c;
      peer.sendFrame(b, 7, 1'b1, (j == 0) ? ~^b : ^b, j == 0);
      rdChk(uart_pkg::ADDR_INTSTAT, 32'h1 << (j + 3), 32'h3c);
      rd(uart_pkg::ADDR_DATA, v);
      wr(uart_pkg::ADDR_INTSTAT, 32'h3f);
      rdChk(uart_pkg::ADDR_INTSTAT, 32'h0, 32'h3c);
    end
    // Thresholds 4 then 14, then overflow of the receive queue
    wr(uart_pkg::ADDR_LCTL, 32'ha83);
    rd(uart_pkg::ADDR_LCTL, v);
    check(v, 32'ha83);
    check(rdData2, 32'h203);
    for (int i = 0; i < 17; i++) begin
      peer.sendFrame(8'(8'h40 + i), 8, 1'b0, 1'b0, 1'b1);
      if (i == 2) pin(rtsN2, 1'b1);
      if (i == 2 || i == 3) begin
        pin(rxDmaReq, i == 3);
        pin(rtsN, i == 3);
      end
      if (i == 3) wr(uart_pkg::ADDR_LCTL, 32'he83);
      if (i == 12 || i == 13) pin(rxDmaReq, i == 13);
    end
    rdChk(uart_pkg::ADDR_STATUS, 32'h1001, 32'h1f01);
    rdChk(uart_pkg::ADDR_INTSTAT, 32'h4, 32'h4);
    for (int i = 0; i < 16; i++) rdChk(uart_pkg::ADDR_DATA, 32'h40 + i, ALL);
    rdChk(uart_pkg::ADDR_DATA, 32'h0, ALL);
    wr(uart_pkg::ADDR_INTSTAT, 32'h3f);
    for (int k = 2; k < 6; k++) begin
      wr(uart_pkg::ADDR_DIAG, 32'h1 << k);
      rdChk(uart_pkg::ADDR_INTSTAT, 32'h1 << k, 32'h3c);
      pin(irq, 1'b0);
      wr(uart_pkg::ADDR_INTMASK, 32'h1 << k);
      @(posedge clk);
      pin(irq, 1'b1);
      wr(uart_pkg::ADDR_INTSTAT, 32'h1 << k);
      @(posedge clk);
      pin(irq, 1'b0);
      wr(uart_pkg::ADDR_INTMASK, 32'h0);
    end
    print_verdict();
  end

  // Whole run is near 13000 clocks; over four times that means a hang
  initial begin
    repeat (60000) @(posedge clk);
    fail_count++;
    print_verdict();
  end
endmodule
